// >>> pkg/ssp_regs.svh
// Constants of the synchronous serial port: bit positions, mode codes and timing
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH
`define SSP_STAT_BUF_FULL_BIT 0
`define SSP_CON2_STRETCH_BIT 0
`define SSP_FLAG_DONE_BIT 3
`define SSP_MODE_SPI_MASTER 4'h0
`define SSP_MODE_SPI_SLAVE_SS 4'h4
`define SSP_MODE_SPI_SLAVE 4'h5
`define SSP_MODE_I2C_SLAVE 4'h6
`define SSP_MODE_I2C_MASTER 4'h8
`define SSP_SYS_CLK_MHZ 100
`define SSP_SPI_HALF_NS 500
`define SSP_SPI_HALF_CYC ((`SSP_SPI_HALF_NS * `SSP_SYS_CLK_MHZ) / 1000)
`define SSP_I2C_HALF_DEFAULT 8'h32
`endif

// >>> pkg/ssp_pkg.sv
// Types of the synchronous serial port
package ssp_pkg;
    typedef enum logic [4:0] {
        SSP_IDLE = 5'b00001,
        SSP_LOW = 5'b00010,
        SSP_HIGH = 5'b00100,
        SSP_WAIT = 5'b01000,
        SSP_DONE = 5'b10000
    } ssp_mst_t;
endpackage : ssp_pkg

// >>> rtl/ssp_sync2.sv
// Two-flip-flop synchroniser for one pin input
`timescale 1ns/1ps
`default_nettype none
module ssp_sync2 (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin_in,
    output logic pin_sync
);
    logic meta_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            meta_q <= pin_in;
            pin_sync <= meta_q;
        end
    end
endmodule : ssp_sync2
`default_nettype wire

// >>> rtl/ssp_port.sv
// Synchronous serial port: receive buffer, flags, SPI and I2C shifting
// Notes on behaviour
// - Full buffer blocks shift-register transfer
// - Buffer read clears buffer-full flag unless a byte completes in the same cycle
// - SPI slave accepts all edge/polarity/select modes
// - Stretch enable holds clock low after byte
// - Master clock pulses keep configured width
// - I2C master waits for slave clock release
// - Second byte while full sets overflow unless the buffer is read in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "ssp_regs.svh"
module ssp_port #(
    parameter int HALF_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] port_mode_select,
    input wire logic clock_edge_select,
    input wire logic clock_polarity_select,
    input wire logic stretch_enable_bit,
    input wire logic [HALF_W-1:0] i2c_half_period,
    input wire logic buf_wr,
    input wire logic [7:0] buf_wdata,
    input wire logic buf_rd,
    output logic [7:0] port_data_buffer,
    output logic buffer_full_flag,
    input wire logic overflow_clr,
    output logic receive_overflow_flag,
    input wire logic done_clr,
    output logic transfer_done_flag,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    input wire logic sdi_in,
    output logic sdo_out,
    input wire logic ss_n_in,
    input wire logic scl_in,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_oe_n
);
    import ssp_pkg::*;

    localparam logic [HALF_W-1:0] SPI_HALF = HALF_W'(`SSP_SPI_HALF_CYC);

    initial begin
        if (HALF_W < 8) $error("HALF_W too small");
    end

    logic sck_s, sdi_s, ss_n_s, scl_s, sda_s;
    logic sck_d1_q, scl_d1_q, sda_d1_q;
    logic [1:0] warm_q;
    ssp_sync2 u_sck (.sys_clk(sys_clk), .rst_n(rst_n), .pin_in(sck_in), .pin_sync(sck_s));
    ssp_sync2 u_sdi (.sys_clk(sys_clk), .rst_n(rst_n), .pin_in(sdi_in), .pin_sync(sdi_s));
    ssp_sync2 u_ss (.sys_clk(sys_clk), .rst_n(rst_n), .pin_in(ss_n_in), .pin_sync(ss_n_s));
    ssp_sync2 u_scl (.sys_clk(sys_clk), .rst_n(rst_n), .pin_in(scl_in), .pin_sync(scl_s));
    ssp_sync2 u_sda (.sys_clk(sys_clk), .rst_n(rst_n), .pin_in(sda_in), .pin_sync(sda_s));

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sck_d1_q <= 1'b0;
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
            warm_q <= 2'h0;
        end else begin
            // SPI slave edge detection waits until the synchroniser holds real pin values
            if (warm_q != 2'h3) begin
                warm_q <= warm_q + 2'h1;
            end
            sck_d1_q <= sck_s;
            scl_d1_q <= scl_s;
            sda_d1_q <= sda_s;
        end
    end

    logic mode_spi_m, mode_spi_s, mode_i2c_s, mode_i2c_m;
    assign mode_spi_m = (port_mode_select == `SSP_MODE_SPI_MASTER);
    assign mode_spi_s = (port_mode_select[3:1] == 3'(`SSP_MODE_SPI_SLAVE_SS >> 1));
    assign mode_i2c_s = (port_mode_select == `SSP_MODE_I2C_SLAVE);
    assign mode_i2c_m = (port_mode_select == `SSP_MODE_I2C_MASTER);
    logic ss_active;
    assign ss_active = port_mode_select[0] | ~ss_n_s;

    // Effective clock level: idle level removed by polarity select
    logic sck_lvl, sck_prev, lead_edge, trail_edge;
    assign sck_lvl = sck_s ^ clock_polarity_select;
    assign sck_prev = sck_d1_q ^ clock_polarity_select;
    assign lead_edge = sck_lvl & ~sck_prev;
    assign trail_edge = ~sck_lvl & sck_prev;
    logic s_sample, s_shift;
    // Edge select swaps sample and shift edges
    assign s_sample = mode_spi_s & ss_active & (warm_q == 2'h3) & (clock_edge_select ? trail_edge : lead_edge);
    assign s_shift = mode_spi_s & ss_active & (warm_q == 2'h3) & (clock_edge_select ? lead_edge : trail_edge);

    logic scl_rise, scl_fall, i2c_start, i2c_stop;
    assign scl_rise = scl_s & ~scl_d1_q;
    assign scl_fall = ~scl_s & scl_d1_q;
    assign i2c_start = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
    assign i2c_stop = scl_s & scl_d1_q & ~sda_d1_q & sda_s;

    // Master clock generator shared by SPI and I2C master
    ssp_mst_t mst_q;
    logic [HALF_W-1:0] cnt_q;
    logic mst_clk_q, m_sample, m_shift, cnt_end;
    logic [HALF_W-1:0] half;
    assign half = mode_i2c_m ? i2c_half_period : SPI_HALF;
    assign cnt_end = (cnt_q == '0);

    logic [7:0] shift_q;
    logic [3:0] bits_q;
    logic byte_done, stretch_q, ack_q;
    logic go;
    assign go = buf_wr & (mode_spi_m | mode_i2c_m) & (mst_q == SSP_IDLE);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mst_q <= SSP_IDLE;
            cnt_q <= '0;
            mst_clk_q <= 1'b0;
        end else begin
            case (mst_q)
                SSP_IDLE: begin
                    mst_clk_q <= 1'b0;
                    if (go) begin
                        mst_q <= SSP_LOW;
                        cnt_q <= half;
                    end
                end
                SSP_LOW: begin
                    if (cnt_end) begin
                        mst_clk_q <= 1'b1;
                        mst_q <= mode_i2c_m ? SSP_WAIT : SSP_HIGH;
                        cnt_q <= half;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                SSP_WAIT: begin
                    if (scl_s) begin
                        mst_q <= SSP_HIGH;
                        cnt_q <= half;
                    end
                end
                SSP_HIGH: begin
                    if (cnt_end) begin
                        mst_clk_q <= 1'b0;
                        cnt_q <= half;
                        // Counter has wrapped to eight after the last sample
                        mst_q <= (bits_q == 4'h8) ? SSP_DONE : SSP_LOW;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                SSP_DONE: mst_q <= SSP_IDLE;
                default: mst_q <= SSP_IDLE;
            endcase
        end
    end
    assign m_sample = ((mst_q == SSP_LOW) & cnt_end & mode_spi_m) | ((mst_q == SSP_WAIT) & scl_s);
    assign m_shift = (mst_q == SSP_HIGH) & cnt_end;

    // Shift register and bit counter
    logic sample_ev, shift_ev;
    logic i2c_s_sample;
    assign i2c_s_sample = mode_i2c_s & scl_rise & ~ack_q;
    assign sample_ev = m_sample | s_sample | i2c_s_sample;
    assign shift_ev = m_shift | s_shift;
    assign byte_done = sample_ev & (bits_q == 4'h1);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            shift_q <= 8'h00;
            bits_q <= 4'h8;
            sdo_out <= 1'b0;
        end else begin
            if (go || (buf_wr && mode_spi_s)) begin
                shift_q <= buf_wdata;
                sdo_out <= buf_wdata[7];
                bits_q <= 4'h8;
            end else if (i2c_start) begin
                bits_q <= 4'h8;
            end else if (sample_ev) begin
                shift_q <= {shift_q[6:0], mode_i2c_s | mode_i2c_m ? sda_s : sdi_s};
                bits_q <= (bits_q == 4'h1) ? 4'h8 : bits_q - 1'b1;
            end else if (shift_ev) begin
                sdo_out <= shift_q[7];
            end
        end
    end

    logic [7:0] rx_byte;
    assign rx_byte = {shift_q[6:0], mode_i2c_s | mode_i2c_m ? sda_s : sdi_s};

    // Receive buffer and status flags
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            port_data_buffer <= 8'h00;
            buffer_full_flag <= 1'b0;
        end else begin
            if (byte_done && !buffer_full_flag) begin
                port_data_buffer <= rx_byte;
                buffer_full_flag <= 1'b1;
            end else if (buf_wr) begin
                port_data_buffer <= buf_wdata;
            end
            if (buf_rd && !byte_done) begin
                buffer_full_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            receive_overflow_flag <= 1'b0;
        end else if (byte_done && buffer_full_flag && !buf_rd) begin
            receive_overflow_flag <= 1'b1;
        end else if (overflow_clr) begin
            receive_overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            transfer_done_flag <= 1'b0;
        end else if (byte_done) begin
            transfer_done_flag <= 1'b1;
        end else if (done_clr) begin
            transfer_done_flag <= 1'b0;
        end
    end

    // I2C slave acknowledge and stretching
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            stretch_q <= 1'b0;
        end else begin
            if (i2c_start || i2c_stop || !mode_i2c_s) begin
                ack_q <= 1'b0;
            end else if (byte_done && mode_i2c_s) begin
                ack_q <= 1'b1;
            end else if (ack_q && scl_fall) begin
                ack_q <= 1'b0;
            end
            if (!mode_i2c_s || !stretch_enable_bit || i2c_stop) begin
                stretch_q <= 1'b0;
            end else if (ack_q && scl_fall) begin
                stretch_q <= 1'b1;
            end else if (buf_rd || buf_wr) begin
                stretch_q <= 1'b0;
            end
        end
    end

    assign sck_out = mst_clk_q ^ clock_polarity_select;
    assign sck_oe_n = ~mode_spi_m;
    assign scl_oe_n = ~(stretch_q | (mode_i2c_m & (mst_q != SSP_IDLE) & ~mst_clk_q));
    assign sda_oe_n = ~((mode_i2c_s & ack_q) | (mode_i2c_m & ~sdo_out & (mst_q != SSP_IDLE)));
endmodule : ssp_port
`default_nettype wire

// >>> verification/ssp_port_asserts.sv
// Checker of buffer flags and clock lines
`timescale 1ns/1ps
`default_nettype none
module ssp_port_asserts (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] port_mode_select,
    input wire logic buf_wr,
    input wire logic buf_rd,
    input wire logic [7:0] port_data_buffer,
    input wire logic buffer_full_flag,
    input wire logic overflow_clr,
    input wire logic receive_overflow_flag,
    input wire logic done_clr,
    input wire logic transfer_done_flag,
    input wire logic sck_oe_n,
    input wire logic scl_in,
    input wire logic scl_oe_n
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    full_block_a: assert property (buffer_full_flag && !buf_wr |=> $stable(port_data_buffer))
        else $error("buffer changed while full");
    full_hold_a: assert property (buffer_full_flag && !buf_rd |=> buffer_full_flag)
        else $error("full dropped without read");
    ovf_cause_a: assert property ($rose(receive_overflow_flag) |-> $past(buffer_full_flag) && buffer_full_flag)
        else $error("overflow without full buffer");
    ovf_hold_a: assert property (receive_overflow_flag && !overflow_clr |=> receive_overflow_flag)
        else $error("overflow dropped");
    done_hold_a: assert property (transfer_done_flag && !done_clr |=> transfer_done_flag)
        else $error("done dropped");
    done_with_full_a: assert property ($rose(buffer_full_flag) |-> transfer_done_flag)
        else $error("byte stored without done");
    slave_clk_quiet_a: assert property (port_mode_select[3:1] == 3'h2 |-> sck_oe_n)
        else $error("slave drives clock");
    stretch_wait_a: assert property (port_mode_select == 4'h8 && scl_oe_n && !scl_in |=> scl_oe_n)
        else $error("master pulled clock while held");
endmodule : ssp_port_asserts
bind ssp_port ssp_port_asserts chk (.sys_clk, .rst_n, .port_mode_select, .buf_wr, .buf_rd, .port_data_buffer,
    .buffer_full_flag, .overflow_clr, .receive_overflow_flag, .done_clr, .transfer_done_flag, .sck_oe_n,
    .scl_in, .scl_oe_n);
`default_nettype wire

// >>> verification/ssp_spi_master_model.sv
// External SPI master that clocks bytes into the port
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_master_model (
    output logic sck,
    output logic sdi,
    output logic ss_n
);
    logic cpol = 1'b0;
    initial begin
        sck = 1'b0;
        sdi = 1'b1;
        ss_n = 1'b1;
    end
    // Data held across both edges, so either sampling edge works
    task automatic send(input logic [7:0] b);
        ss_n = 1'b0;
        #40;
        for (int i = 7; i >= 0; i--) begin
            sdi = b[i];
            #31.25 sck = ~cpol;
            #62.5 sck = cpol;
            #31.25;
        end
        // Released line shows the inverse of the last bit
        sdi = ~b[0];
        ss_n = 1'b1;
    endtask : send
endmodule : ssp_spi_master_model
`default_nettype wire

// >>> verification/testbench.sv
// Bench of the serial port receive buffer and flags
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk, rst_n, cke, cpol, ste, wr, rd, oclr, dclr, hold;
    logic full, ovf, done, sck, sdi, ss_n, sdo, sck_oe_n, scl_oe_n, sda_oe_n;
    logic [3:0] mode;
    logic [7:0] half, wdata, data, b;
    int n_errors = 0;
    int samples_checked = 0;
    int n;
    ssp_spi_master_model m (.sck(sck), .sdi(sdi), .ss_n(ss_n));
    ssp_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .port_mode_select(mode), .clock_edge_select(cke),
        .clock_polarity_select(cpol), .stretch_enable_bit(ste), .i2c_half_period(half), .buf_wr(wr),
        .buf_wdata(wdata), .buf_rd(rd), .port_data_buffer(data), .buffer_full_flag(full),
        .overflow_clr(oclr), .receive_overflow_flag(ovf), .done_clr(dclr), .transfer_done_flag(done),
        .sck_in(sck), .sck_out(), .sck_oe_n(sck_oe_n), .sdi_in(sdi), .sdo_out(sdo), .ss_n_in(ss_n),
        .scl_in(scl_oe_n & ~hold), .scl_oe_n(scl_oe_n), .sda_in(sda_oe_n), .sda_oe_n(sda_oe_n));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic give_verdict;
        if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string s);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: %s", $time, s);
            n_errors++;
        end
    endtask : chk8
    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask : pulse
    task automatic reset_dut;
        rst_n = 1'b0;
        tick(20);
        rst_n = 1'b1;
    endtask : reset_dut
    task automatic wait_done;
        for (int i = 0; i < 400 && done !== 1'b1; i++) tick(1);
        chk8({7'h00, done}, 8'h01, "no transfer done");
        if (done !== 1'b1) give_verdict();
    endtask : wait_done
    initial begin
        {rst_n, cke, cpol, ste, wr, rd, oclr, dclr, hold} = '0;
        mode = 4'h5;
        half = 8'h03;
        wdata = 8'h00;
        tick(1);
        reset_dut();
        chk8({full, ovf, done, scl_oe_n, sck_oe_n}, 8'h03, "reset flags");
        chk8(data, 8'h00, "reset buffer");
        for (int k = 0; k < 4; k++) begin
            mode = k[0] ? 4'h5 : 4'h4;
            cke = k[1];
            cpol = k[0] ^ k[1];
            m.cpol = cpol;
            m.sck = cpol;
            reset_dut();
            b = 8'h96 ^ 8'(k * 17);
            m.send(b);
            wait_done();
            chk8({7'h00, full}, 8'h01, "full not set");
            chk8(data, b, "slave byte");
            pulse(rd);
            chk8({7'h00, full}, 8'h00, "full not cleared");
        end
        pulse(dclr);
        chk8({7'h00, done}, 8'h00, "done not cleared");
        m.send(8'hc3);
        wait_done();
        pulse(dclr);
        m.send(8'h3c);
        wait_done();
        chk8({7'h00, ovf}, 8'h01, "overflow not set");
        chk8(data, 8'hc3, "full buffer overwritten");
        pulse(oclr);
        pulse(rd);
        pulse(dclr);
        m.send(8'h3c);
        wait_done();
        chk8({6'h00, full, ovf}, 8'h02, "byte after read");
        chk8(data, 8'h3c, "buffer after read");
        mode = 4'h8;
        reset_dut();
        wdata = 8'h55;
        pulse(rd);
        pulse(wr);
        for (int i = 0; i < 100 && scl_oe_n !== 1'b0; i++) tick(1);
        chk8({7'h00, scl_oe_n}, 8'h00, "master clock not started");
        if (scl_oe_n !== 1'b0) give_verdict();
        // Far side holds the first low phase
        hold = 1'b1;
        tick(30);
        chk8({7'h00, scl_oe_n}, 8'h01, "clock driven while held");
        hold = 1'b0;
        for (int i = 0; i < 100 && scl_oe_n !== 1'b0; i++) tick(1);
        chk8({7'h00, scl_oe_n}, 8'h00, "no clock after release");
        if (scl_oe_n !== 1'b0) give_verdict();
        n = 0;
        while (scl_oe_n === 1'b0 && n < 50) begin
            n++;
            tick(1);
        end
        chk8(8'(n), half + 8'h01, "clock low width");
        wait_done();
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
